/* inc/drum_seq_pkg.sv */
// constants, register map and field layout of the event step sequencer
// assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus
package drum_seq_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int unsigned STEPS     = 16;
   localparam int unsigned OUTS      = 16;
   localparam int unsigned STEP_W    = 4;
   localparam int unsigned WORD_W    = 16;
   localparam int unsigned CONTACTS  = 32;
   localparam int unsigned SEL_W     = 5;
   localparam int unsigned ADDR_W    = 10;
   localparam int unsigned DATA_W    = 32;

   // ************************************************************
   // timing: one timebase unit is 0.01 s
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned TICK_UNIT_NS     = 10000000;
   localparam int unsigned TICK_CYCLES_DFLT = TICK_UNIT_NS / CLK_PERIOD_NS;

   // ************************************************************
   // register map, byte addresses
   // ************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL      = 10'h000;
   localparam logic [ADDR_W-1:0] ADDR_TIMEBASE  = 10'h004;
   localparam logic [ADDR_W-1:0] ADDR_IN_STEP   = 10'h008;
   localparam logic [ADDR_W-1:0] ADDR_TIMER     = 10'h00C;
   localparam logic [ADDR_W-1:0] ADDR_PRESET    = 10'h010;
   localparam logic [ADDR_W-1:0] ADDR_CURRENT   = 10'h014;
   localparam logic [ADDR_W-1:0] ADDR_LAST      = 10'h018;
   // per-step tables: group number is addr[9:6], entry is addr[5:2]
   localparam logic [3:0] GRP_SCALAR  = 4'h0;
   localparam logic [3:0] GRP_CPS     = 4'h4;
   localparam logic [3:0] GRP_EVENT   = 4'h5;
   localparam logic [3:0] GRP_PATTERN = 4'h6;
   localparam logic [3:0] GRP_MASK    = 4'h7;
   localparam logic [3:0] GRP_MAP     = 4'h8;

   // ************************************************************
   // fields
   // ************************************************************
   localparam int unsigned CTRL_RUN      = 0;
   localparam int unsigned CTRL_MASK_EN  = 1;
   localparam int unsigned CTRL_WORD     = 2;
   localparam int unsigned CTRL_W        = 3;
   localparam int unsigned EVT_EN        = 5;
   localparam int unsigned MAP_EN        = 4;
   localparam int unsigned DONE_BIT      = 16;
   localparam logic [4:0]  PRESET_RST    = 5'h01;
   localparam logic [4:0]  LAST_RST      = 5'h10;
   localparam logic [4:0]  STEP_MAX      = 5'h10;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RUN  = 3'h2,
      ST_DONE = 3'h4
   } seq_state_t;

endpackage : drum_seq_pkg

/* hdl/drum_timebase.sv */
// timebase for the step sequencer: 0.01 s prescaler and count ticks
// assumes enable and clear come from the sequencer in the same clock
`timescale 1ns/1ps
module drum_timebase
#(
   parameter int unsigned TICK_CYCLES = drum_seq_pkg::TICK_CYCLES_DFLT
)
(
   input  wire logic                            core_clk_i,
   input  wire logic                            arst_n_i,
   input  wire logic                            enable_i,
   input  wire logic                            clear_i,
   input  wire logic [drum_seq_pkg::WORD_W-1:0] timebase_i,
   output logic                                 count_tick_o,
   output logic      [drum_seq_pkg::WORD_W-1:0] timer_value_o
);
   import drum_seq_pkg::*;

   localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

   logic [PRE_W-1:0]  pre_r;
   logic              unit_tick;
   logic [WORD_W-1:0] timer_nxt;

   // free-running so a held timer resumes on the same unit grid
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pre_r <= '0;
      else if (pre_r == PRE_LAST)
         pre_r <= '0;
      else
         pre_r <= pre_r + PRE_W'(1);
   end

   assign unit_tick = (pre_r == PRE_LAST);
   assign timer_nxt = timer_value_o + WORD_W'(1);

   // a zero timebase never produces a count tick
   assign count_tick_o = enable_i && unit_tick && (timebase_i != '0)
                         && (timer_nxt == timebase_i);

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         timer_value_o <= '0;
      else if (clear_i || count_tick_o)
         timer_value_o <= '0;
      else if (enable_i && unit_tick && (timebase_i != '0))
         timer_value_o <= timer_nxt;
   end

endmodule : drum_timebase

/* hdl/event_step_sequencer.sv */
// sixteen-step event sequencer with mask, word output and AXI4-Lite map
// assumes start, jog, reset and contacts are synchronous to core_clk_i
`timescale 1ns/1ps
module event_step_sequencer
#(
   parameter int unsigned TICK_CYCLES = drum_seq_pkg::TICK_CYCLES_DFLT
)
(
   input  wire logic                              core_clk_i,
   input  wire logic                              arst_n_i,
   // control inputs from the scan logic
   input  wire logic                              start_i,
   input  wire logic                              jog_i,
   input  wire logic                              drum_reset_i,
   input  wire logic [drum_seq_pkg::CONTACTS-1:0] event_contacts_i,
   // outputs
   output logic      [drum_seq_pkg::OUTS-1:0]     points_o,
   output logic      [drum_seq_pkg::WORD_W-1:0]   word_o,
   output logic                                   drum_complete_flag_o,
   // AXI4-Lite slave
   input  wire logic [drum_seq_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [drum_seq_pkg::DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic      [1:0]                        s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [drum_seq_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic      [drum_seq_pkg::DATA_W-1:0]   s_axi_rdata,
   output logic      [1:0]                        s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready
);
   import drum_seq_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [CTRL_W-1:0]  ctrl_r;
   logic [WORD_W-1:0]  timebase_r;
   logic [4:0]         preset_r;
   logic [4:0]         last_r;
   logic [WORD_W-1:0]  cps_r     [STEPS];
   logic [EVT_EN:0]    event_r   [STEPS];
   logic [OUTS-1:0]    pattern_r [STEPS];
   logic [OUTS-1:0]    mask_r    [STEPS];
   logic [MAP_EN:0]    map_r     [OUTS];

   logic               aw_hold_r;
   logic               w_hold_r;
   logic [ADDR_W-1:0]  awaddr_r;
   logic [DATA_W-1:0]  wdata_r;
   logic [3:0]         wstrb_r;
   logic               wr_do;
   logic [WORD_W-1:0]  wr_mask;
   logic [3:0]         wr_grp;
   logic [STEP_W-1:0]  wr_idx;
   logic               wr_ok;
   logic [3:0]         rd_grp;
   logic [STEP_W-1:0]  rd_idx;
   logic [DATA_W-1:0]  rd_data;
   logic               rd_ok;

   seq_state_t         state_r;
   logic [STEP_W-1:0]  step_r;
   logic [WORD_W-1:0]  in_step_r;
   logic               jog_d_r;
   logic               run_d_r;
   logic               jog_rise;
   logic               run_rise;
   logic               load;
   logic               ev_true;
   logic               timer_en;
   logic               count_tick;
   logic               reached;
   logic               advance;
   logic [WORD_W-1:0]  timer_value;
   logic [STEP_W-1:0]  preset_idx;
   logic [STEP_W-1:0]  last_idx;
   logic [OUTS-1:0]    result;
   logic [OUTS-1:0]    points_nxt;

   function automatic logic [STEP_W-1:0] to_idx(input logic [4:0] v);
      logic [4:0] t;
      t = v - 5'h01;
      if (v == 5'h00 || v > STEP_MAX)
         return '0;
      return t[STEP_W-1:0];
   endfunction : to_idx

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
   assign wr_do   = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign wr_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign wr_grp  = awaddr_r[9:6];
   assign wr_idx  = awaddr_r[5:2];

   always_comb
   begin
      case (wr_grp)
         GRP_SCALAR: wr_ok = (awaddr_r == ADDR_CTRL)
                             || (awaddr_r == ADDR_TIMEBASE)
                             || (awaddr_r == ADDR_PRESET)
                             || (awaddr_r == ADDR_LAST);
         GRP_CPS, GRP_EVENT, GRP_PATTERN, GRP_MASK, GRP_MAP:
            wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // address and data are taken in either order, then answered together
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_hold_r    <= 1'b0;
         w_hold_r     <= 1'b0;
         awaddr_r     <= '0;
         wdata_r      <= '0;
         wstrb_r      <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   // preset may be rewritten while running; it takes effect on next load
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_r     <= '0;
         timebase_r <= '0;
         preset_r   <= PRESET_RST;
         last_r     <= LAST_RST;
      end
      else if (wr_do && wr_grp == GRP_SCALAR && wstrb_r[0])
      begin
         if (awaddr_r == ADDR_CTRL)
            ctrl_r <= wdata_r[CTRL_W-1:0];
         if (awaddr_r == ADDR_PRESET)
            preset_r <= wdata_r[4:0];
         if (awaddr_r == ADDR_LAST)
            last_r <= wdata_r[4:0];
         if (awaddr_r == ADDR_TIMEBASE)
            timebase_r <= (timebase_r & ~wr_mask)
                          | (wdata_r[WORD_W-1:0] & wr_mask);
      end
      else if (wr_do && awaddr_r == ADDR_TIMEBASE)
         timebase_r <= (timebase_r & ~wr_mask)
                       | (wdata_r[WORD_W-1:0] & wr_mask);
   end

   // per-step tables; reset leaves every step blank with no event
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int k = 0; k < STEPS; k++)
         begin
            cps_r[k]     <= '0;
            event_r[k]   <= '0;
            pattern_r[k] <= '0;
            mask_r[k]    <= '0;
            map_r[k]     <= '0;
         end
      end
      else if (wr_do)
      begin
         case (wr_grp)
            GRP_CPS:
               cps_r[wr_idx] <= (cps_r[wr_idx] & ~wr_mask)
                                | (wdata_r[WORD_W-1:0] & wr_mask);
            GRP_EVENT:
               if (wstrb_r[0])
                  event_r[wr_idx] <= wdata_r[EVT_EN:0];
            GRP_PATTERN:
               pattern_r[wr_idx] <= (pattern_r[wr_idx] & ~wr_mask)
                                    | (wdata_r[OUTS-1:0] & wr_mask);
            GRP_MASK:
               mask_r[wr_idx] <= (mask_r[wr_idx] & ~wr_mask)
                                 | (wdata_r[OUTS-1:0] & wr_mask);
            GRP_MAP:
               if (wstrb_r[0])
                  map_r[wr_idx] <= wdata_r[MAP_EN:0];
            default: ;
         endcase
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_grp = s_axi_araddr[9:6];
   assign rd_idx = s_axi_araddr[5:2];

   always_comb
   begin
      rd_data = '0;
      rd_ok   = 1'b1;
      case (rd_grp)
         GRP_SCALAR:
            case (s_axi_araddr)
               ADDR_CTRL:     rd_data[CTRL_W-1:0] = ctrl_r;
               ADDR_TIMEBASE: rd_data[WORD_W-1:0] = timebase_r;
               ADDR_IN_STEP:
               begin
                  rd_data[WORD_W-1:0] = in_step_r;
                  rd_data[DONE_BIT]   = drum_complete_flag_o;
               end
               ADDR_TIMER:    rd_data[WORD_W-1:0] = timer_value;
               ADDR_PRESET:   rd_data[4:0] = preset_r;
               ADDR_CURRENT:  rd_data[4:0] = {1'b0, step_r} + 5'h01;
               ADDR_LAST:     rd_data[4:0] = last_r;
               default:       rd_ok = 1'b0;
            endcase
         GRP_CPS:     rd_data[WORD_W-1:0] = cps_r[rd_idx];
         GRP_EVENT:   rd_data[EVT_EN:0]   = event_r[rd_idx];
         GRP_PATTERN: rd_data[OUTS-1:0]   = pattern_r[rd_idx];
         GRP_MASK:    rd_data[OUTS-1:0]   = mask_r[rd_idx];
         GRP_MAP:     rd_data[MAP_EN:0]   = map_r[rd_idx];
         default:     rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ************************************************************
   // step sequencing
   // ************************************************************
   assign preset_idx = to_idx(preset_r);
   assign last_idx   = (last_r == 5'h00) ? STEP_W'(STEPS - 1)
                                         : to_idx(last_r);
   assign jog_rise   = jog_i && !jog_d_r;
   assign run_rise   = ctrl_r[CTRL_RUN] && !run_d_r;
   assign load       = run_rise
                       || (drum_reset_i && state_r != ST_IDLE);
   // a step with no event enabled is treated as event always true
   assign ev_true    = !event_r[step_r][EVT_EN]
                       || event_contacts_i[event_r[step_r][SEL_W-1:0]];
   assign timer_en   = (state_r == ST_RUN) && !drum_reset_i
                       && start_i && ev_true;
   // zero counts per step means the step is event-driven only
   assign reached    = (cps_r[step_r] == '0) ? timer_en
                       : (count_tick
                          && in_step_r + WORD_W'(1) == cps_r[step_r]);
   assign advance    = (state_r == ST_RUN) && !drum_reset_i && !run_rise
                       && (jog_rise || reached);

   drum_timebase #(
      .TICK_CYCLES   (TICK_CYCLES)
   ) u_timebase (
      .core_clk_i    (core_clk_i),
      .arst_n_i      (arst_n_i),
      .enable_i      (timer_en),
      .clear_i       (load || advance),
      .timebase_i    (timebase_r),
      .count_tick_o  (count_tick),
      .timer_value_o (timer_value)
   );

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         jog_d_r <= 1'b0;
         run_d_r <= 1'b0;
      end
      else
      begin
         jog_d_r <= jog_i;
         run_d_r <= ctrl_r[CTRL_RUN];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_r              <= ST_IDLE;
         step_r               <= '0;
         in_step_r            <= '0;
         drum_complete_flag_o <= 1'b0;
      end
      else if (!ctrl_r[CTRL_RUN])
      begin
         state_r <= ST_IDLE;
         // reset input clears the flag outside run mode as well
         if (drum_reset_i)
            drum_complete_flag_o <= 1'b0;
      end
      else if (load)
      begin
         state_r              <= ST_RUN;
         step_r               <= preset_idx;
         in_step_r            <= '0;
         drum_complete_flag_o <= 1'b0;
      end
      else
         case (state_r)
            ST_RUN:
               if (advance && step_r == last_idx)
               begin
                  state_r              <= ST_DONE;
                  drum_complete_flag_o <= 1'b1;
               end
               else if (advance)
               begin
                  step_r    <= step_r + STEP_W'(1);
                  in_step_r <= '0;
               end
               else if (count_tick)
                  in_step_r <= in_step_r + WORD_W'(1);
            ST_DONE: state_r <= ST_DONE;
            default: state_r <= ST_IDLE;
         endcase
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // run entry is seen here one cycle after the bit is written
   assign result = (state_r == ST_IDLE) ? '0
                   : ctrl_r[CTRL_MASK_EN]
                     ? (pattern_r[step_r] & mask_r[step_r])
                     : pattern_r[step_r];

   // several positions may share a point; they are ORed together
   for (genvar j = 0; j < OUTS; j++)
   begin : g_point
      always_comb
      begin
         points_nxt[j] = 1'b0;
         for (int k = 0; k < OUTS; k++)
            if (map_r[k][MAP_EN] && map_r[k][STEP_W-1:0] == STEP_W'(j))
               points_nxt[j] = points_nxt[j] | result[k];
      end
   end

   // refreshed on every clock whatever start does; sharing points
   // between two sequencers would fight
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         points_o <= '0;
         word_o   <= '0;
      end
      else if (ctrl_r[CTRL_WORD])
      begin
         points_o <= '0;
         word_o   <= result;
      end
      else
      begin
         points_o <= points_nxt;
         word_o   <= '0;
      end
   end

endmodule : event_step_sequencer

/* testbench/drum_contacts_model.sv */
// ladder-side contact model: one commanded contact, the rest random
// assumes sel_i and level_i are driven by the bench
`timescale 1ns/1ps
module drum_contacts_model
(
   input  wire logic        clk_i,
   input  wire logic [4:0]  sel_i,
   input  wire logic        level_i,
   output logic      [31:0] contacts_o = '0
);
   // other contacts take a new random level every cycle so no stale level is trusted
   always_ff @(posedge clk_i)
   begin
      contacts_o <= $urandom;
      contacts_o[sel_i] <= level_i;
   end
endmodule : drum_contacts_model

/* testbench/drum_seq_checker.sv */
// checker: flag, output and bus relations at the sequencer ports
// assumes a bind onto event_step_sequencer
`timescale 1ns/1ps
module drum_seq_checker
(
   input wire logic        core_clk_i,
   input wire logic        arst_n_i,
   input wire logic        drum_reset_i,
   input wire logic        drum_complete_flag_o,
   input wire logic [15:0] points_o,
   input wire logic [15:0] word_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid
);
   // ****
   // properties
   // ****
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   chk_rd_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   chk_wr_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_aw_busy: assert property
      (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_out_excl: assert property
      (word_o != 16'h0 |-> points_o == 16'h0)
      else $error("word and points both driven");
   chk_flag_clear: assert property
      (drum_reset_i |=> !drum_complete_flag_o)
      else $error("flag kept through reset");
   chk_flag_hold: assert property
      (drum_complete_flag_o && !drum_reset_i |=> drum_complete_flag_o)
      else $error("flag lost without reset");
   chk_flag_cause: assert property
      ($rose(drum_complete_flag_o) |-> !$past(drum_reset_i))
      else $error("flag set during reset");
endmodule : drum_seq_checker

bind event_step_sequencer drum_seq_checker chk (.*);

/* testbench/test_event_step_sequencer.sv */
// bench: bus master, jog, start and reset stimulus, output model
// assumes the contacts model and the checker are compiled first
`timescale 1ns/1ps
module test_event_step_sequencer;
   import drum_seq_pkg::*;
   logic        core_clk_i = '0, arst_n_i = '0, start_i = '0, jog_i = '0;
   logic        drum_reset_i = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, event_contacts_i, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [15:0] points_o, word_o;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        drum_complete_flag_o, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, lvl = '0, mon = '0;
   logic [4:0]  sel = '0;
   int          fail_count = 0, checks_done = 0, pat[16], msk[16], k;
   event_step_sequencer #(.TICK_CYCLES(4)) dut (.*);
   drum_contacts_model pm (.clk_i(core_clk_i), .sel_i(sel), .level_i(lvl),
      .contacts_o(event_contacts_i));
   initial
      forever #20 core_clk_i = ~core_clk_i;
   task automatic report_and_stop;
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, exp, input string what);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge core_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [9:0] a);
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge core_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic look(input int s, input logic wm);
      logic [15:0] e;
      e = pat[s-1] & (mon ? msk[s-1] : 32'hFFFF);
      repeat (3) @(posedge core_clk_i);
      rd(ADDR_CURRENT);
      chk(d, s, "current");
      chk(points_o, wm ? 16'h0 : e, "points");
      chk(word_o, wm ? e : 16'h0, "word");
   endtask : look
   // ****
   // main sequence
   // ****
   initial
   begin
      void'($urandom(32'hE822));
      repeat (6) @(posedge core_clk_i);
      arst_n_i <= 1'h1;
      rd(ADDR_PRESET);
      chk(d, 32'h1, "preset");
      rd(10'h3FC);
      chk(rsp, RESP_SLVERR, "unmapped");
      chk(points_o, 16'h0, "idle points");
      for (k = 0; k < 16; k++)
      begin
         pat[k] = $urandom;
         msk[k] = $urandom;
         wr(10'h180 + 4 * k, pat[k]);
         wr(10'h1C0 + 4 * k, msk[k]);
         wr(10'h200 + 4 * k, 32'h10 + k);
      end
      wr(ADDR_PRESET, 32'h3);
      wr(ADDR_CTRL, 32'h1);
      chk(rsp, RESP_OKAY, "bresp");
      look(3, 0);
      for (k = 4; k <= 17; k++)
      begin
         @(posedge core_clk_i);
         jog_i <= 1'h1;
         repeat (2) @(posedge core_clk_i);
         jog_i <= 1'h0;
         look(k > 16 ? 16 : k, 0);
      end
      chk(drum_complete_flag_o, 1'h1, "flag");
      rd(ADDR_IN_STEP);
      chk(d[DONE_BIT], 1'h1, "flag bit");
      wr(ADDR_PRESET, 32'h5);
      look(16, 0);
      drum_reset_i <= 1'h1;
      repeat (3) @(posedge core_clk_i);
      drum_reset_i <= 1'h0;
      chk(drum_complete_flag_o, 1'h0, "flag");
      look(5, 0);
      mon = 1'h1;
      wr(ADDR_CTRL, 32'h3);
      look(5, 0);
      msk[4] = $urandom;
      wr(10'h1D0, msk[4]);
      look(5, 0);
      wr(ADDR_CTRL, 32'h7);
      look(5, 1);
      sel <= 5'($urandom);
      wr(ADDR_TIMEBASE, 32'h1);
      wr(10'h110, 32'h2);
      wr(10'h114, 32'h1);
      wr(10'h118, 32'h64);
      wr(10'h154, 32'h20 | sel);
      start_i <= 1'h1;
      repeat (40) @(posedge core_clk_i);
      look(6, 1);
      lvl <= 1'h1;
      repeat (40) @(posedge core_clk_i);
      look(7, 1);
      start_i <= 1'h0;
      repeat (500) @(posedge core_clk_i);
      look(7, 1);
      report_and_stop();
   end
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      fail_count++;
      report_and_stop();
   end
endmodule : test_event_step_sequencer
